//--- rtl/lcd_segment_timing_driver.sv
// Segment LCD timing driver: AXI4-Lite registers, frame timing, common/segment drive.
// Assumes oscillator and sleep inputs come from other domains; the glass sees
// digital drive levels plus enables (analog bias is outside).
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module lcd_segment_timing_driver
   import lcd_timing_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Oscillators and processor sleep (asynchronous)
   input wire logic fastOsc,
   input wire logic secondaryOsc,
   input wire logic lprcOsc,
   input wire logic cpuSleep,
   // Panel pins and frame interrupt
   output panel_drive_t panel,
   output logic [NUM_SEG-1:0] pinOut,
   output logic frameIrq
);
   // Synchronised inputs and source ticks
   logic fastS, secS, lprcS, sleepS;
   logic fastTick, secTick, lprcTick;
   lcd_sync2 uSyncFast (.clk(clk), .arst_n(arst_n), .din(fastOsc), .dout(fastS));
   lcd_sync2 uSyncSec (.clk(clk), .arst_n(arst_n), .din(secondaryOsc), .dout(secS));
   lcd_sync2 uSyncLprc (.clk(clk), .arst_n(arst_n), .din(lprcOsc), .dout(lprcS));
   lcd_sync2 uSyncSleep (.clk(clk), .arst_n(arst_n), .din(cpuSleep), .dout(sleepS));
   lcd_src_div #(.DIV(FAST_OSC_DIV)) uDivFast (
      .clk(clk), .arst_n(arst_n), .oscLevel(fastS), .tick(fastTick));
   lcd_src_div #(.DIV(SLOW_OSC_DIV)) uDivSec (
      .clk(clk), .arst_n(arst_n), .oscLevel(secS), .tick(secTick));
   lcd_src_div #(.DIV(SLOW_OSC_DIV)) uDivLprc (
      .clk(clk), .arst_n(arst_n), .oscLevel(lprcS), .tick(lprcTick));

   // Registers
   logic [31:0] control_reg, phase_reg, ladder_reg;
   logic irqFlag_reg, irqEnable_reg;
   logic [NUM_SEG-1:0] direction_reg, segEnable_reg;
   logic [31:0] pixel_reg [PIXEL_WORDS];
   logic [2:0] mux;
   logic [3:0] prescale;
   logic enable, typeB, sleepStop, halted, frozen;
   clk_src_t src;
   assign mux = control_reg[CTL_MUX_LSB +: 3];
   assign src = clk_src_t'(control_reg[CTL_CS_LSB +: 2]);
   assign enable = control_reg[CTL_ENABLE_BIT];
   assign sleepStop = control_reg[CTL_SLEEP_STOP_BIT];
   assign prescale = phase_reg[PS_PRESCALE_LSB +: 4];
   assign typeB = phase_reg[PS_TYPEB_BIT];
   assign halted = sleepS && sleepStop;
   assign frozen = sleepS && !sleepStop;

   // AXI write channel
   logic awHeld_reg, wHeld_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite, writeBlocked, pixelHit;
   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign pixelHit = awAddr_reg >= PIXEL_OFS;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_bresp = 2'b00;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Frame timing
   logic [3:0] preCnt_reg;
   logic [1:0] subCnt_reg;
   logic [2:0] slice_reg;
   logic phase_bit_reg, oddFrame_reg, srcTick, sliceTick, frameEnd;
   logic [1:0] subLimit;
   always_comb begin
      case (src)
         SRC_FAST: srcTick = fastTick;
         SRC_SECONDARY: srcTick = secTick;
         SRC_LOW_POWER_RC_OSCILLATOR: srcTick = lprcTick;
         default: srcTick = 1'b0;
      endcase
   end
   // Static slices split in 4, half mux in 2
   assign subLimit = (mux == 3'h0) ? 2'(STATIC_FACTOR - 1) :
                     (mux == 3'h1) ? 2'(HALF_FACTOR - 1) : 2'h0;
   assign sliceTick = srcTick && enable && !halted && preCnt_reg == prescale &&
                      subCnt_reg == subLimit;
   assign frameEnd = sliceTick && slice_reg == mux;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         preCnt_reg <= 4'h0;
         subCnt_reg <= 2'h0;
      end else if (!enable || halted) begin
         preCnt_reg <= 4'h0;
         subCnt_reg <= 2'h0;
      end else if (srcTick) begin
         if (preCnt_reg == prescale) begin
            preCnt_reg <= 4'h0;
            subCnt_reg <= (subCnt_reg == subLimit) ? 2'h0 : subCnt_reg + 2'h1;
         end else begin
            preCnt_reg <= preCnt_reg + 4'h1;
         end
      end
   end
   // Slice, phase within slice, frame parity
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slice_reg <= 3'h0;
         phase_bit_reg <= 1'b0;
         oddFrame_reg <= 1'b0;
      end else if (!enable || halted) begin
         slice_reg <= 3'h0;
         phase_bit_reg <= 1'b0;
         oddFrame_reg <= 1'b0;
      end else if (srcTick && preCnt_reg == prescale) begin
         if (!typeB || mux == 3'h0) begin
            phase_bit_reg <= (subCnt_reg == subLimit / 2'h2 || subCnt_reg == subLimit) ?
                             !phase_bit_reg : phase_bit_reg;
         end
         if (sliceTick) begin
            slice_reg <= frameEnd ? 3'h0 : slice_reg + 3'h1;
            if (frameEnd) begin
               oddFrame_reg <= !oddFrame_reg;
            end
         end
      end
   end
   logic inversion;
   assign inversion = (typeB && mux != 3'h0) ? oddFrame_reg : phase_bit_reg;

   // Write window: while enabled, Type-B multiplex accepts pixel writes only in the subframe after the flag
   logic writeOpen;
   assign writeOpen = !(typeB && mux != 3'h0) || oddFrame_reg;
   assign writeBlocked = frozen || !writeOpen;

   // Control, phase, ladder, direction and segment enable writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         control_reg <= CONTROL_RST;
         phase_reg <= PHASE_RST;
         ladder_reg <= LADDER_RST;
         direction_reg <= '0;
         segEnable_reg <= '0;
         irqEnable_reg <= 1'b0;
      end else begin
         if (doWrite && pixelHit && enable && writeBlocked) begin
            control_reg[CTL_WRITE_ERROR_FLAG_BIT] <= 1'b1;
         end
         if (doWrite) begin
            case (awAddr_reg)
               CONTROL_OFS: begin
                  control_reg <= merge(control_reg, wData_reg, wStrb_reg) & 32'h0000_A07F;
                  if (control_reg[CTL_WRITE_ERROR_FLAG_BIT] && !wData_reg[CTL_WRITE_ERROR_FLAG_BIT]) begin
                     control_reg[CTL_WRITE_ERROR_FLAG_BIT] <= pixelHit;
                  end
               end
               PHASE_OFS: phase_reg <= merge(phase_reg, wData_reg, wStrb_reg) & 32'h0000_00FF;
               LADDER_OFS: ladder_reg <= merge(ladder_reg, wData_reg, wStrb_reg) & 32'h0000_BFF7;
               IRQ_OFS: irqEnable_reg <= wData_reg[IRQ_ENABLE_BIT];
               DIR_OFS: direction_reg[31:0] <= merge(direction_reg[31:0], wData_reg, wStrb_reg);
               8'h14: direction_reg[63:32] <= merge(direction_reg[63:32], wData_reg, wStrb_reg);
               SEGEN_OFS: segEnable_reg[31:0] <= merge(segEnable_reg[31:0], wData_reg, wStrb_reg);
               8'h24: segEnable_reg[63:32] <= merge(segEnable_reg[63:32], wData_reg, wStrb_reg);
               default: ;
            endcase
         end
      end
   end

   // Pixel storage: word w holds common w/2, segments (w%2)*32.. ; spare bits are plain RAM
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < PIXEL_WORDS; i++) begin
            pixel_reg[i] <= 32'h0000_0000;
         end
      end else if (doWrite && pixelHit && !(enable && writeBlocked) && !frozen) begin
         pixel_reg[awAddr_reg[5:2]] <= merge(pixel_reg[awAddr_reg[5:2]], wData_reg,
                                             wStrb_reg);
      end
   end

   // Frame flag: Type-B multiplex only, at end of even frame (oddFrame_reg low), once per frame pair
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqFlag_reg <= 1'b0;
      end else if (frameEnd && typeB && mux != 3'h0 && oddFrame_reg == 1'b0) begin
         irqFlag_reg <= 1'b1;
      end else if (doWrite && awAddr_reg == IRQ_OFS && !wData_reg[IRQ_FLAG_BIT]) begin
         irqFlag_reg <= 1'b0;
      end
   end
   assign frameIrq = irqFlag_reg && irqEnable_reg;

   // Read channel
   logic [31:0] rdVal;
   always_comb begin
      rdVal = 32'h0000_0000;
      if (s_axi_araddr >= PIXEL_OFS) begin
         rdVal = pixel_reg[s_axi_araddr[5:2]];
      end else begin
         case (s_axi_araddr)
            CONTROL_OFS: rdVal = control_reg;
            PHASE_OFS: rdVal = phase_reg;
            LADDER_OFS: rdVal = ladder_reg;
            IRQ_OFS: rdVal = {30'h0, irqEnable_reg, irqFlag_reg};
            DIR_OFS: rdVal = direction_reg[31:0];
            8'h14: rdVal = direction_reg[63:32];
            SEGEN_OFS: rdVal = segEnable_reg[31:0];
            8'h24: rdVal = segEnable_reg[63:32];
            8'h28: rdVal = {26'h0, oddFrame_reg, slice_reg, 2'h0};
            default: rdVal = 32'h0000_0000;
         endcase
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdVal;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_rresp = 2'b00;

   // Panel drive: active common high, seg = dark xor active polarity, all flipped by inversion
   panel_drive_t drive_next;
   always_comb begin
      drive_next = '0;
      for (int c = 0; c < 8; c++) begin
         drive_next.comEn[c] = enable && (3'(c) <= mux);
         drive_next.com[c] = (3'(c) == slice_reg) ^ inversion;
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         drive_next.segEn[s] = enable && segEnable_reg[s];
         drive_next.seg[s] = pixel_reg[{slice_reg, 1'b0} + 4'(s / 32)][s % 32] ^ inversion;
      end
      // Upper commons double as segment drivers only up to quarter mux
      if (mux > 3'h3) begin
         drive_next.segEn[NUM_SEG-1 -: 4] = 4'h0;
      end
      if (halted) begin
         drive_next.com = 8'h00;
         drive_next.seg = '0;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         panel <= '0;
      end else begin
         panel <= drive_next;
      end
   end
   // Output enable of plain I/O pins from direction bits (1 = output)
   assign pinOut = direction_reg & ~panel.segEn;

   a_mux_com_enable: assert property (@(posedge clk) disable iff (!arst_n)
      enable |=> panel.comEn[0]) else $error("first common not driven");
   a_no_irq_typea: assert property (@(posedge clk) disable iff (!arst_n)
      (!typeB && $rose(irqFlag_reg)) |-> 1'b0) else $error("flag in Type-A");
   a_halt_min: assert property (@(posedge clk) disable iff (!arst_n)
      halted |=> (panel.com == 8'h00 || !$past(halted))) else $error("halt not low");
   a_upper_seg: assert property (@(posedge clk) disable iff (!arst_n)
      mux > 3'h3 |=> panel.segEn[NUM_SEG-1] == 1'b0 || $past(mux) <= 3'h3)
      else $error("upper common as segment");
   a_write_error_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
      (doWrite && pixelHit && enable && writeBlocked) |=> control_reg[CTL_WRITE_ERROR_FLAG_BIT])
      else $error("write error missed");
   a_frame_wrap: assert property (@(posedge clk) disable iff (!arst_n)
      frameEnd |=> slice_reg == 3'h0) else $error("frame not restarted");
   a_irq_end: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(irqFlag_reg) |-> $past(frameEnd)) else $error("flag off boundary");
   a_frozen_data: assert property (@(posedge clk) disable iff (!arst_n)
      frozen && $past(frozen) |-> $stable(pixel_reg[0])) else $error("data changed");
endmodule : lcd_segment_timing_driver

//--- rtl/lcd_src_div.sv
// Divider: one-cycle tick every DIV rising edges of an already synchronised oscillator level.
// Assumes oscLevel is on clk's domain.
`timescale 1ns/10ps
module lcd_src_div #(
   parameter int DIV = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Oscillator level and tick out
   input wire logic oscLevel,
   output logic tick
);
   logic last_reg;
   logic [13:0] cnt_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_reg <= 1'b0;
         cnt_reg <= 14'h0000;
         tick <= 1'b0;
      end else begin
         last_reg <= oscLevel;
         tick <= 1'b0;
         if (oscLevel && !last_reg) begin
            if (cnt_reg == 14'(DIV - 1)) begin
               cnt_reg <= 14'h0000;
               tick <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 14'h0001;
            end
         end
      end
   end
endmodule : lcd_src_div

//--- rtl/lcd_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is clk.
`timescale 1ns/10ps
module lcd_sync2 (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Level in and out
   input wire logic din,
   output logic dout
);
   logic meta_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule : lcd_sync2

//--- rtl/lcd_timing_pkg.sv
// Package for the segment LCD timing driver: register map, fields, resets, types.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
package lcd_timing_pkg;
   // Register byte offsets
   localparam logic [7:0] CONTROL_OFS = 8'h00;
   localparam logic [7:0] PHASE_OFS = 8'h04;
   localparam logic [7:0] LADDER_OFS = 8'h08;
   localparam logic [7:0] IRQ_OFS = 8'h0C;
   localparam logic [7:0] DIR_OFS = 8'h10;
   localparam logic [7:0] SEGEN_OFS = 8'h20;
   localparam logic [7:0] PIXEL_OFS = 8'h40;
   localparam int SEGEN_WORDS = 4;
   localparam int PIXEL_WORDS = 16;
   localparam int NUM_SEG = 64;
   // Control register fields
   localparam int CTL_ENABLE_BIT = 15;
   localparam int CTL_SLEEP_STOP_BIT = 6;
   localparam int CTL_WRITE_ERROR_FLAG_BIT = 5;
   localparam int CTL_CS_LSB = 3;
   localparam int CTL_MUX_LSB = 0;
   // Phase register fields
   localparam int PS_TYPEB_BIT = 7;
   localparam int PS_PRESCALE_LSB = 0;
   // Interrupt register fields
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_ENABLE_BIT = 1;
   // Reset values
   localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] PHASE_RST = 32'h0000_0000;
   localparam logic [31:0] LADDER_RST = 32'h0000_0000;
   localparam logic [2:0] MUX_RST = 3'h0;
   // Source clock dividers and slice split factors
   localparam int FAST_OSC_DIV = 8192;
   localparam int SLOW_OSC_DIV = 32;
   localparam int STATIC_FACTOR = 4;
   localparam int HALF_FACTOR = 2;
   // Clock source choices
   typedef enum logic [1:0] {SRC_FAST, SRC_SECONDARY, SRC_LOW_POWER_RC_OSCILLATOR, SRC_NONE} clk_src_t;
   // Panel drive levels carried together
   typedef struct packed {
      logic [7:0] com;
      logic [7:0] comEn;
      logic [NUM_SEG-1:0] seg;
      logic [NUM_SEG-1:0] segEn;
   } panel_drive_t;
endpackage : lcd_timing_pkg

//--- test/lcd_glass_model.sv
// Glass panel model: watches the first common line's drive and enable, counts frame starts.
// Assumes digital drive levels and enables come straight from the timing driver.
`timescale 1ns/10ps
module lcd_glass_model
   import lcd_timing_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Panel drive
   input wire panel_drive_t panel,
   // Observations
   output int frameStarts
);
   logic com0Last;
   // A frame begins at the leading edge of the first common line
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         com0Last <= 1'b0;
         frameStarts <= 0;
      end else begin
         com0Last <= panel.com[0];
         if (panel.comEn[0] && panel.com[0] && !com0Last) frameStarts <= frameStarts + 1;
      end
   end
endmodule : lcd_glass_model

//--- test/lcd_segment_timing_driver_bench.sv
// Self-checking bench for the segment LCD timing driver over AXI4-Lite.
// Assumes the register map and frame timing of the designer's package and notes.
`timescale 1ns/10ps
module lcd_segment_timing_driver_bench
   import lcd_timing_pkg::*;
;
   logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, frameIrq;
   logic fastOsc, secondaryOsc, lprcOsc, cpuSleep;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [1:0] bresp, rresp;
   logic [2:0] oscCnt;
   panel_drive_t panel;
   logic [NUM_SEG-1:0] pinOut;
   logic [63:0] dirM, segM;
   logic [31:0] pix [PIXEL_WORDS];
   logic [1:0] srcT [3] = '{2'h1, 2'h2, 2'h1};
   logic [2:0] muxT [3] = '{3'h1, 3'h2, 3'h7};
   logic [3:0] pT [3] = '{4'h1, 4'h0, 4'h2};
   int frameStarts, err_total, comparisons, seed, n, i, tk, expCyc;
   longint t0;

   lcd_segment_timing_driver uut (
      .clk(clk), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fastOsc(fastOsc), .secondaryOsc(secondaryOsc), .lprcOsc(lprcOsc), .cpuSleep(cpuSleep),
      .panel(panel), .pinOut(pinOut), .frameIrq(frameIrq)
   );
   lcd_glass_model glass (.clk(clk), .arst_n(arst_n), .panel(panel), .frameStarts(frameStarts));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Oscillators: fast every 2, secondary every 4, low-power RC every 8 cycles
   always @(posedge clk) begin
      oscCnt <= oscCnt + 3'h1;
      fastOsc <= oscCnt[0];
      secondaryOsc <= oscCnt[1];
      lprcOsc <= oscCnt[2];
   end

   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [63:0] g, input logic [63:0] e, input string what);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t %s got %h want %h", $time, what, g, e);
      end
   endtask : check
   task automatic stall(input string what);
      err_total++;
      $display("BAD %0t timeout on %s", $time, what);
      give_verdict();
   endtask : stall
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 100) stall("write");
      check(bresp, 2'b00, "write response");
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      rready <= 1'b0;
      if (k == 100) stall("read");
      check(rresp, 2'b00, "read response");
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      check(d, e, "register read");
   endtask : rdchk
   task automatic wait_irq();
      for (n = 0; n < 20000 && frameIrq !== 1'b1; n++) @(posedge clk);
      if (n == 20000) stall("frame flag");
   endtask : wait_irq
   function automatic logic [31:0] ctl(input logic en, input logic stop, input logic [1:0] src,
                                       input logic [2:0] mux);
      return (32'(en) << CTL_ENABLE_BIT) | (32'(stop) << CTL_SLEEP_STOP_BIT)
         | (32'(src) << CTL_CS_LSB) | 32'(mux);
   endfunction : ctl
   function automatic logic [31:0] phase(input logic b, input logic [3:0] p);
      return (32'(b) << PS_TYPEB_BIT) | 32'(p);
   endfunction : phase

   initial begin
      seed = 32'h638a;
      err_total = 0;
      comparisons = 0;
      arst_n = 1'b0;
      oscCnt = 3'h0;
      {awvalid, wvalid, bready, arvalid, rready, cpuSleep} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0000_0000_0000;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(CONTROL_OFS, CONTROL_RST);
      rdchk(PHASE_OFS, PHASE_RST);
      rdchk(LADDER_OFS, LADDER_RST);
      check(panel.segEn, 64'h0, "segment enables after reset");
      check(pinOut, 64'h0, "pin outputs after reset");
      wr(8'h30, $random(seed));
      rdchk(8'h30, 32'h0000_0000);
      for (i = 0; i < PIXEL_WORDS; i++) begin
         pix[i] = $random(seed);
         wr(8'(PIXEL_OFS + 4 * i), pix[i]);
      end
      for (i = 0; i < PIXEL_WORDS; i++) rdchk(8'(PIXEL_OFS + 4 * i), pix[i]);
      dirM = {$random(seed), $random(seed)};
      segM = {$random(seed), $random(seed)};
      wr(PHASE_OFS, phase(1'b0, 4'h0));
      for (i = 0; i < 2; i++) begin
         wr(8'(DIR_OFS + 4 * i), dirM[32*i+:32]);
         wr(8'(SEGEN_OFS + 4 * i), segM[32*i+:32]);
      end
      wr(LADDER_OFS, 32'h0000_87F7);
      rdchk(LADDER_OFS, 32'h0000_87F7);
      wr(CONTROL_OFS, ctl(1'b1, 1'b0, 2'h1, 3'h3));
      repeat (4) @(posedge clk);
      check(pinOut, dirM & ~segM, "segment enable over direction");
      for (i = 0; i < 3; i++) begin
         wr(CONTROL_OFS, 32'h0000_0000);
         wr(PHASE_OFS, phase(1'b1, pT[i]));
         wr(IRQ_OFS, 32'h0000_0002);
         wr(CONTROL_OFS, ctl(1'b1, 1'b0, srcT[i], muxT[i]));
         if (i == 0) begin
            wr(PIXEL_OFS, ~pix[0]);
            rdchk(PIXEL_OFS, pix[0]);
            rd(CONTROL_OFS, got);
            check(got[CTL_WRITE_ERROR_FLAG_BIT], 1'b1, "write error flag");
         end
         wait_irq();
         t0 = $time;
         check(panel.comEn, 8'((16'h1 << (muxT[i] + 1)) - 1), "commons in use");
         if (muxT[i] > 3'h3) check(panel.segEn[63:60], 4'h0, "upper commons not segments");
         if (i == 0) begin
            pix[0] = ~pix[0];
            wr(PIXEL_OFS, pix[0]);
            rdchk(PIXEL_OFS, pix[0]);
         end
         wr(IRQ_OFS, 32'h0000_0002);
         wait_irq();
         n = int'(($time - t0) / 10);
         tk = (muxT[i] == 3'h1) ? HALF_FACTOR * 2 * (pT[i] + 1) : (muxT[i] + 1) * (pT[i] + 1);
         expCyc = 2 * tk * SLOW_OSC_DIV * ((srcT[i] == 2'h1) ? 4 : 8);
         check(n >= expCyc - 8 && n <= expCyc + 8, 1'b1, "frame pair length");
      end
      for (i = 0; i < 2; i++) begin
         wr(CONTROL_OFS, 32'h0000_0000);
         wr(IRQ_OFS, 32'h0000_0002);
         wr(PHASE_OFS, phase(i[0], 4'h0));
         wr(CONTROL_OFS, ctl(1'b1, 1'b0, 2'h2, i[0] ? 3'h0 : 3'h3));
         tk = frameStarts;
         for (n = 0; n < 3000 && frameIrq !== 1'b1; n++) @(posedge clk);
         check(n, 3000, "no frame flag");
         check(frameStarts > tk, 1'b1, "frames keep running");
      end
      wr(PHASE_OFS, phase(1'b0, 4'h0));
      wr(CONTROL_OFS, ctl(1'b1, 1'b1, 2'h1, 3'h3));
      cpuSleep <= 1'b1;
      repeat (10) @(posedge clk);
      tk = frameStarts;
      repeat (600) @(posedge clk);
      check(panel.com, 8'h00, "sleep commons low");
      check(panel.seg, 64'h0, "sleep segments low");
      check(frameStarts, tk, "sleep halts frames");
      cpuSleep <= 1'b0;
      wr(CONTROL_OFS, ctl(1'b1, 1'b0, 2'h1, 3'h3));
      cpuSleep <= 1'b1;
      repeat (600) @(posedge clk);
      wr(PIXEL_OFS, ~pix[0]);
      rdchk(PIXEL_OFS, pix[0]);
      check(frameStarts > tk, 1'b1, "display runs in sleep");
      cpuSleep <= 1'b0;
      give_verdict();
   end
endmodule : lcd_segment_timing_driver_bench
